// ===== design/output_polarity_sync_alarm_ctrl.sv
// Purpose: Control word for output polarity, software sync and pointer
//          alarms, with sticky alarm flags and an interrupt, over APB.
// Assumes: APB master per the protocol; all inputs synchronous to mclk.
// Notes:   Zero wait states; unmapped addresses answer with pslverr.

`default_nettype none

module output_polarity_sync_alarm_ctrl
	import pol_sync_alarm_pkg::*;
(
	input  wire logic              mclk,           // Block clock, 25 MHz.
	input  wire logic              rst_n,          // Synchronous reset, active low.
	input  wire logic              psel,           // APB select.
	input  wire logic              penable,        // APB access phase.
	input  wire logic              pwrite,         // APB direction, high for write.
	input  wire logic [ADDR_W-1:0] paddr,          // APB byte address.
	input  wire logic [31:0]       pwdata,         // APB write data.
	input  wire logic [3:0]        pstrb,          // APB byte strobes.
	output logic      [31:0]       prdata,         // APB read data.
	output logic                   pready,         // APB ready.
	output logic                   pslverr,        // APB error.
	input  wire logic [CODE_W-1:0] dac_a_code_in,  // Sample code for converter A.
	input  wire logic [CODE_W-1:0] dac_b_code_in,  // Sample code for converter B.
	output logic      [CODE_W-1:0] dac_a_code,     // Code sent to converter A.
	output logic      [CODE_W-1:0] dac_b_code,     // Code sent to converter B.
	input  wire logic              ext_sync_in,    // External sync input.
	output logic                   chip_sync,      // Chip-wide sync.
	output logic                   sync_pulse,     // Software sync pulse.
	input  wire logic              ptr_two_apart,  // Pointers within two.
	input  wire logic              ptr_one_apart,  // Pointers within one.
	input  wire logic              ptr_collision,  // Pointers collide.
	output logic      [ALM_W-1:0]  alarm_en,       // Alarm enables to the buffer.
	output logic                   output_off,     // Converter outputs off.
	output logic                   irq             // Interrupt, active high.
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------

	// Expands byte strobes into a 32-bit bit mask.
	function automatic logic [31:0] lane_mask(input logic [3:0] strb);
		logic [31:0] m;
		m = '0;
		for (int i = 0; i < 4; i++)
		begin
			m[i*8 +: 8] = {8{strb[i]}};
		end
		return m;
	endfunction

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------

	logic        wr_acc;     // Write access phase.
	logic        setup;      // Setup phase of any transfer.
	logic        hit_ctrl;   // Address selects the control word.
	logic        hit_stat;   // Address selects the status flags.
	logic        hit_mask;   // Address selects the mask.
	logic        mapped;     // Address selects any register.
	logic [31:0] wmask;      // Strobe-qualified write bits.

	// The slave never inserts wait states.
	assign pready   = 1'b1;
	assign setup    = psel & ~penable;
	assign wr_acc   = psel & penable & pwrite;
	assign hit_ctrl = (paddr == OFF_CONTROL);
	assign hit_stat = (paddr == OFF_STATUS);
	assign hit_mask = (paddr == OFF_MASK);
	assign mapped   = hit_ctrl | hit_stat | hit_mask;
	assign wmask    = lane_mask(pstrb);

	// ------------------------------------------------------------
	// Control and mask registers
	// ------------------------------------------------------------

	logic [CTRL_W-1:0] ctrl;       // Control word.
	logic [CTRL_W-1:0] next_ctrl;  // Next control word.
	logic [ALM_W-1:0]  mask;       // Interrupt mask.
	logic [ALM_W-1:0]  next_mask;  // Next mask.
	logic [ALM_W-1:0]  stat_clr;   // Write-one-to-clear strobes.

	// Writes land only in the access phase and only on writable bits.
	always_comb
	begin
		next_ctrl = ctrl;
		next_mask = mask;
		stat_clr  = '0;
		if (wr_acc && hit_ctrl)
		begin
			next_ctrl = (ctrl & ~(CTRL_WMASK & wmask[CTRL_W-1:0]))
				| (pwdata[CTRL_W-1:0] & CTRL_WMASK & wmask[CTRL_W-1:0]);
		end
		if (wr_acc && hit_mask)
		begin
			next_mask = (mask & ~wmask[ALM_W-1:0])
				| (pwdata[ALM_W-1:0] & wmask[ALM_W-1:0]);
		end
		if (wr_acc && hit_stat)
		begin
			stat_clr = pwdata[ALM_W-1:0] & wmask[ALM_W-1:0];
		end
	end

	// Register control state.
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			ctrl <= CTRL_RESET;
			mask <= MASK_RESET;
		end
		else
		begin
			ctrl <= next_ctrl;
			mask <= next_mask;
		end
	end

	// ------------------------------------------------------------
	// Alarm flags and interrupt
	// ------------------------------------------------------------

	logic [ALM_W-1:0] alarm_cond;    // Raw pointer conditions.
	logic [ALM_W-1:0] alarm_set;     // Conditions gated by their enables.
	logic [ALM_W-1:0] alarm_status;  // Sticky flags.

	// Only an enabled condition may set its flag. The live control bits gate it,
	// not the published copy, so a cleared enable blocks the very next cycle.
	always_comb
	begin
		alarm_cond           = '0;
		alarm_cond[ALM_TWO]  = ptr_two_apart;
		alarm_cond[ALM_ONE]  = ptr_one_apart;
		alarm_cond[ALM_COLL] = ptr_collision;
		alarm_set            = '0;
		alarm_set[ALM_TWO]   = alarm_cond[ALM_TWO] & ctrl[BIT_TWO_EN];
		alarm_set[ALM_ONE]   = alarm_cond[ALM_ONE] & ctrl[BIT_ONE_EN];
		alarm_set[ALM_COLL]  = alarm_cond[ALM_COLL] & ctrl[BIT_COLL_EN];
	end

	alarm_flags #(
		.N (ALM_W)
	) u_flags (
		.mclk   (mclk),
		.rst_n  (rst_n),
		.set_in (alarm_set),
		.clr_in (stat_clr),
		.flags  (alarm_status)
	);

	// Level interrupt while any unmasked flag is set.
	assign irq = |(alarm_status & mask);

	// ------------------------------------------------------------
	// Software sync
	// ------------------------------------------------------------

	sync_pulse_gen u_sync (
		.mclk        (mclk),
		.rst_n       (rst_n),
		.sw_sync_bit (ctrl[BIT_SW_SYNC]),
		.sw_mode_en  (ctrl[BIT_SW_SYNCEN]),
		.ext_sync    (ext_sync_in),
		.sync_pulse  (sync_pulse),
		.chip_sync   (chip_sync)
	);

	// ------------------------------------------------------------
	// Datapath: polarity, enables and shutdown
	// ------------------------------------------------------------

	logic [CODE_W-1:0] next_a_code;    // Next converter A code.
	logic [CODE_W-1:0] next_b_code;    // Next converter B code.
	logic [ALM_W-1:0]  next_alarm_en;  // Next alarm enables.
	logic              next_off;       // Next shutdown level.

	// Invert codes per channel, publish enables, compute shutdown.
	always_comb
	begin
		next_a_code = dac_a_code_in ^ {CODE_W{ctrl[BIT_POL_A]}};
		next_b_code = dac_b_code_in ^ {CODE_W{ctrl[BIT_POL_B]}};
		next_alarm_en           = '0;
		next_alarm_en[ALM_TWO]  = ctrl[BIT_TWO_EN];
		next_alarm_en[ALM_ONE]  = ctrl[BIT_ONE_EN];
		next_alarm_en[ALM_COLL] = ctrl[BIT_COLL_EN];
		// Shutdown needs both the alarm and the shutdown enabled.
		next_off = ptr_collision & ctrl[BIT_COLL_EN] & ctrl[BIT_COLL_SHUT];
	end

	// Register datapath outputs.
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			dac_a_code <= '0;
			dac_b_code <= '0;
			alarm_en   <= '0;
			output_off <= 1'b0;
		end
		else
		begin
			dac_a_code <= next_a_code;
			dac_b_code <= next_b_code;
			alarm_en   <= next_alarm_en;
			output_off <= next_off;
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------

	logic [31:0] next_prdata;   // Read data captured in setup.
	logic        next_pslverr;  // Error captured in setup.

	// Capture the answer in the setup phase so it is a flop in access.
	always_comb
	begin
		next_prdata  = prdata;
		next_pslverr = pslverr;
		if (setup)
		begin
			next_prdata  = '0;
			next_pslverr = ~mapped;
			if (!pwrite)
			begin
				case (1'b1)
					hit_ctrl: next_prdata[CTRL_W-1:0] = ctrl;
					hit_stat: next_prdata[ALM_W-1:0]  = alarm_status;
					hit_mask: next_prdata[ALM_W-1:0]  = mask;
					default:  next_prdata             = '0;
				endcase
			end
		end
	end

	// Register the read answer.
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			prdata  <= '0;
			pslverr <= 1'b0;
		end
		else
		begin
			prdata  <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------

	logic [CODE_W-1:0] exp_a;  // Expected A code one cycle later.
	logic [CODE_W-1:0] exp_b;  // Expected B code one cycle later.
	logic              mode;   // Software sync mode enable.
	logic              swbit;  // Software sync bit.

	assign exp_a = dac_a_code_in ^ {CODE_W{ctrl[BIT_POL_A]}};
	assign exp_b = dac_b_code_in ^ {CODE_W{ctrl[BIT_POL_B]}};
	assign mode  = ctrl[BIT_SW_SYNCEN];
	assign swbit = ctrl[BIT_SW_SYNC];

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	a_pol_a_invert: assert property (##1 dac_a_code == $past(exp_a))
		else $error("Channel A code not inverted as set.");

	a_pol_b_invert: assert property (##1 dac_b_code == $past(exp_b))
		else $error("Channel B code not inverted as set.");

	a_sw_sync_route: assert property (mode && $rose(swbit) |=> chip_sync)
		else $error("Software sync edge did not reach chip sync.");

	a_ext_sync_route: assert property (!mode |=> chip_sync == $past(ext_sync_in))
		else $error("External sync not used outside software mode.");

	a_fall_no_pulse: assert property ($fell(swbit) |=> !sync_pulse ##1 !sync_pulse)
		else $error("Falling sync bit made a pulse.");

	a_pulse_single: assert property (sync_pulse |=> !sync_pulse)
		else $error("Sync pulse longer than one cycle.");

	a_two_apart_set: assert property (ptr_two_apart && ctrl[BIT_TWO_EN]
		|=> alarm_status[ALM_TWO])
		else $error("Two-apart alarm not flagged.");

	a_one_apart_set: assert property (ptr_one_apart && ctrl[BIT_ONE_EN]
		|=> alarm_status[ALM_ONE])
		else $error("One-apart alarm not flagged.");

	a_collision_set: assert property (ptr_collision && ctrl[BIT_COLL_EN]
		|=> alarm_status[ALM_COLL])
		else $error("Collision alarm not flagged.");

	a_coll_shutdown: assert property (ptr_collision && ctrl[BIT_COLL_EN]
		&& ctrl[BIT_COLL_SHUT] |=> output_off)
		else $error("Collision did not shut outputs off.");

	a_disabled_quiet: assert property ($rose(alarm_status[ALM_TWO])
		|-> $past(ptr_two_apart && ctrl[BIT_TWO_EN]))
		else $error("Disabled two-apart alarm set a flag.");

	a_no_shut_disabled: assert property (!ctrl[BIT_COLL_EN] |=> !output_off)
		else $error("Disabled collision alarm shut outputs off.");

endmodule

`default_nettype wire

// ===== pkg/pol_sync_alarm_pkg.sv
// What this block does
// - Channel A polarity bit inverts converter A code.
// - Channel B polarity bit inverts converter B code.
// - Software sync mode routes sync bit as chip sync.
// - Pulse only on sync bit rising edge.
// - Software sync mode active only while enabled.
// - Two-apart enable lets near pointers raise alarm.
// - One-apart enable lets adjacent pointers raise alarm.
// - Collision enable lets pointer collision raise alarm.
// - Collision shutdown turns outputs off on collision, only while collision enable is also set.
//
// Purpose: Shared constants for the polarity, sync and alarm control block.
// Assumes: A 32-bit APB register bus, one word per register.
// Notes:   Only the lower control bits of the control word live here.

`default_nettype none

package pol_sync_alarm_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int CODE_W = 14;  // Converter sample code width.
	localparam int ADDR_W = 8;   // Decoded APB address width.
	localparam int CTRL_W = 16;  // Control word width.
	localparam int ALM_W  = 3;   // Number of alarm kinds.

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFF_CONTROL = 8'h00;  // Control word.
	localparam logic [ADDR_W-1:0] OFF_STATUS  = 8'h04;  // Sticky alarm flags.
	localparam logic [ADDR_W-1:0] OFF_MASK    = 8'h08;  // Interrupt mask.

	// ------------------------------------------------------------
	// Control word fields
	// ------------------------------------------------------------
	localparam int BIT_COLL_SHUT = 9;  // Collision shuts outputs off.
	localparam int BIT_POL_A     = 7;  // Invert channel A code.
	localparam int BIT_POL_B     = 6;  // Invert channel B code.
	localparam int BIT_SW_SYNC   = 5;  // Software sync level.
	localparam int BIT_SW_SYNCEN = 4;  // Software sync mode enable.
	localparam int BIT_TWO_EN    = 3;  // Two-apart alarm enable.
	localparam int BIT_ONE_EN    = 2;  // One-apart alarm enable.
	localparam int BIT_COLL_EN   = 1;  // Collision alarm enable.

	localparam logic [CTRL_W-1:0] CTRL_RESET = 16'h000E;  // Alarms enabled.
	localparam logic [CTRL_W-1:0] CTRL_WMASK = 16'h02FE;  // Writable bits.

	// ------------------------------------------------------------
	// Alarm flag positions in status and mask
	// ------------------------------------------------------------
	localparam int ALM_COLL = 0;  // Collision.
	localparam int ALM_ONE  = 1;  // One apart.
	localparam int ALM_TWO  = 2;  // Two apart.

	localparam logic [ALM_W-1:0] MASK_RESET = 3'h0;  // All masked off.

endpackage

`default_nettype wire

// ===== design/sync_pulse_gen.sv
// Purpose: Builds the software sync pulse and selects the chip sync.
// Assumes: All inputs are synchronous to mclk.
// Notes:   Only a rising edge of the software bit makes a pulse.

`default_nettype none

module sync_pulse_gen
	import pol_sync_alarm_pkg::*;
(
	input  wire logic mclk,         // Block clock.
	input  wire logic rst_n,        // Synchronous reset, active low.
	input  wire logic sw_sync_bit,  // Software sync level from control word.
	input  wire logic sw_mode_en,   // Software sync mode enable.
	input  wire logic ext_sync,     // External sync input.
	output logic      sync_pulse,   // One-cycle software sync pulse.
	output logic      chip_sync     // Chip-wide sync signal.
);

	logic prev_bit;         // Software bit one cycle ago.
	logic next_prev_bit;    // Next value of prev_bit.
	logic next_sync_pulse;  // Next value of sync_pulse.
	logic next_chip_sync;   // Next value of chip_sync.

	// Edge detect and source selection.
	always_comb
	begin
		next_prev_bit   = sw_sync_bit;
		next_sync_pulse = sw_sync_bit & ~prev_bit;
		if (sw_mode_en)
		begin
			// Mode on: the pulse replaces the external sync.
			next_chip_sync = next_sync_pulse;
		end
		else
		begin
			next_chip_sync = ext_sync;
		end
	end

	// Register the edge detector and outputs.
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			prev_bit   <= 1'b0;
			sync_pulse <= 1'b0;
			chip_sync  <= 1'b0;
		end
		else
		begin
			prev_bit   <= next_prev_bit;
			sync_pulse <= next_sync_pulse;
			chip_sync  <= next_chip_sync;
		end
	end

endmodule

`default_nettype wire

// ===== design/alarm_flags.sv
// Purpose: Sticky alarm flags set by enabled conditions, cleared by software.
// Assumes: Conditions and clears are synchronous to mclk.
// Notes:   A set in the same cycle as a clear wins.

`default_nettype none

module alarm_flags
	import pol_sync_alarm_pkg::*;
#(
	parameter int N = ALM_W  // Number of flags.
)
(
	input  wire logic         mclk,    // Block clock.
	input  wire logic         rst_n,   // Synchronous reset, active low.
	input  wire logic [N-1:0] set_in,  // Enabled conditions this cycle.
	input  wire logic [N-1:0] clr_in,  // Write-one-to-clear strobes.
	output logic      [N-1:0] flags    // Sticky flags.
);

	logic [N-1:0] next_flags;  // Next value of flags.

	// Clear first, then set, so a new event is never lost.
	always_comb
	begin
		next_flags = (flags & ~clr_in) | set_in;
	end

	// Register the flags.
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			flags <= '0;
		end
		else
		begin
			flags <= next_flags;
		end
	end

endmodule

`default_nettype wire

// ===== verification/tb_top.sv
// Purpose: Self-checking bench for the polarity, sync and alarm control block.
// Assumes: Zero-wait APB slave; datapath outputs lag their inputs by one cycle.
// Notes:   Random stimulus from a fixed seed, with corner cases mixed in.

`default_nettype none

// Compares a design value with the expected one and counts the result.
`define CHK(got, exp) \
	begin \
		n_compared++; \
		if ((got) !== (exp)) \
		begin \
			error_cnt++; \
			$display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); \
		end \
	end

module tb_top
	import pol_sync_alarm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic              mclk;        // Bench clock, 25 MHz.
	logic              rst_n;       // Synchronous reset, active low.
	logic              psel;        // APB select.
	logic              penable;     // APB access phase.
	logic              pwrite;      // APB direction.
	logic [ADDR_W-1:0] paddr;       // APB address.
	logic [31:0]       pwdata;      // APB write data.
	logic [3:0]        pstrb;       // APB byte strobes.
	logic [31:0]       prdata;      // APB read data.
	logic              pready;      // APB ready.
	logic              pslverr;     // APB error.
	logic [CODE_W-1:0] code_a_in;   // Sample code into channel A.
	logic [CODE_W-1:0] code_b_in;   // Sample code into channel B.
	logic [CODE_W-1:0] code_a;      // Code out of channel A.
	logic [CODE_W-1:0] code_b;      // Code out of channel B.
	logic              ext_sync;    // External sync input.
	logic              chip_sync;   // Chip-wide sync.
	logic              sync_pulse;  // Software sync pulse.
	logic [ALM_W-1:0]  ptr_cond;    // Pointer conditions: two, one, collision.
	logic [ALM_W-1:0]  alarm_en;    // Alarm enables to the buffer.
	logic              output_off;  // Output shutdown.
	logic              irq;         // Interrupt.
	int                error_cnt;   // Mismatches seen.
	int                n_compared;  // Comparisons made.
	int                cyc = 0;     // Cycles since start, for the hang guard.
	logic [31:0]       rd;          // Read data of the last transfer.
	logic              err;         // Error flag of the last transfer.

	// ------------------------------------------------------------
	// Device under test
	// ------------------------------------------------------------
	output_polarity_sync_alarm_ctrl i_dut (
		.mclk          (mclk),
		.rst_n         (rst_n),
		.psel          (psel),
		.penable       (penable),
		.pwrite        (pwrite),
		.paddr         (paddr),
		.pwdata        (pwdata),
		.pstrb         (pstrb),
		.prdata        (prdata),
		.pready        (pready),
		.pslverr       (pslverr),
		.dac_a_code_in (code_a_in),
		.dac_b_code_in (code_b_in),
		.dac_a_code    (code_a),
		.dac_b_code    (code_b),
		.ext_sync_in   (ext_sync),
		.chip_sync     (chip_sync),
		.sync_pulse    (sync_pulse),
		.ptr_two_apart (ptr_cond[2]),
		.ptr_one_apart (ptr_cond[1]),
		.ptr_collision (ptr_cond[0]),
		.alarm_en      (alarm_en),
		.output_off    (output_off),
		.irq           (irq)
	);

	// Clock generator.
	initial
	begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// Hang guard: a run far beyond the expected length ends in failure.
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 8000)
		begin
			error_cnt++;
			give_verdict();
		end
	end

	// ------------------------------------------------------------
	// Tasks and functions
	// ------------------------------------------------------------
	// One APB transfer; the request is held until pready is seen high.
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge mclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		pstrb   <= s;
		@(posedge mclk);
		penable <= 1'b1;
		// Only pready seen high or the bench's hang guard ends this wait.
		do
		begin
			@(posedge mclk);
		end
		while (pready !== 1'b1);
		`CHK(pready, 1'b1)
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Waits k rising edges, then lets their updates land.
	task automatic tick(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask

	// Expected converter code for a given polarity setting.
	function automatic logic [CODE_W-1:0] exp_code(input logic [CODE_W-1:0] c, input logic p);
		return p ? ~c : c;
	endfunction

	// Marks the end of one test.
	task automatic done(input string s);
		$display("test %s finished, errors so far %0d", s, error_cnt);
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic give_verdict();
		$display("compared=%0d errors=%0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		int               i;
		int               j;
		logic [31:0]      d;
		logic [CODE_W-1:0] a;
		logic [CODE_W-1:0] b;
		logic [2:0]       c;
		logic [2:0]       e;
		logic             x;
		error_cnt = 0;
		n_compared = 0;
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		pstrb = 4'h0;
		code_a_in = '0;
		code_b_in = '0;
		ext_sync = 1'b0;
		ptr_cond = '0;
		void'($urandom(29322));
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		// Reset values: all three alarms enabled, no flags, mask clear.
		apb(1'b0, OFF_CONTROL, 32'h0, 4'hF);
		`CHK(rd, 32'h0000000E)
		apb(1'b0, OFF_STATUS, 32'h0, 4'hF);
		`CHK(rd, 32'h00000000)
		apb(1'b0, OFF_MASK, 32'h0, 4'hF);
		`CHK(rd, 32'h00000000)
		`CHK(alarm_en, 3'h7)
		done("reset");
		// Random control words: writable bits stick, enables and channel A polarity follow.
		for (i = 0; i < 8; i++)
		begin
			d = $urandom;
			apb(1'b1, OFF_CONTROL, d, 4'hF);
			apb(1'b0, OFF_CONTROL, 32'h0, 4'hF);
			`CHK(rd, {16'h0, d[15:0] & CTRL_WMASK})
			`CHK(alarm_en, d[3:1])
			`CHK(code_a, exp_code('0, d[7]))
		end
		// Only the strobed lane is written.
		// The low lane keeps the value read back in the last pass above.
		d = {16'h0, {8'hFF, rd[7:0]} & CTRL_WMASK};
		apb(1'b1, OFF_CONTROL, 32'hFFFFFFFF, 4'h2);
		apb(1'b0, OFF_CONTROL, 32'h0, 4'hF);
		`CHK(rd, d)
		// Unmapped address: error, zero data, no write.
		apb(1'b1, 8'h0C, 32'hFFFFFFFF, 4'hF);
		`CHK(err, 1'b1)
		apb(1'b0, 8'h0C, 32'h0, 4'hF);
		`CHK(rd, 32'h0)
		apb(1'b0, OFF_CONTROL, 32'h0, 4'hF);
		`CHK(rd, d)
		done("registers");
		// Polarity: every combination, with all-zero and all-one codes first.
		for (i = 0; i < 4; i++)
		begin
			apb(1'b1, OFF_CONTROL, 32'h0E | (i << 6), 4'hF);
			for (j = 0; j < 6; j++)
			begin
				a = (j == 0) ? '0 : (j == 1) ? '1 : CODE_W'($urandom);
				b = (j == 1) ? '0 : (j == 0) ? '1 : CODE_W'($urandom);
				@(posedge mclk);
				code_a_in <= a;
				code_b_in <= b;
				tick(1);
				`CHK(code_a, exp_code(a, i[1]))
				`CHK(code_b, exp_code(b, i[0]))
			end
		end
		done("polarity");
		// Software sync mode: external sync is ignored, a rise makes one pulse.
		apb(1'b1, OFF_CONTROL, 32'h1E, 4'hF);
		@(posedge mclk);
		ext_sync <= 1'b1;
		tick(2);
		`CHK(chip_sync, 1'b0)
		apb(1'b1, OFF_CONTROL, 32'h3E, 4'hF);
		#1;
		`CHK(sync_pulse, 1'b0)
		tick(1);
		`CHK(sync_pulse, 1'b1)
		`CHK(chip_sync, 1'b1)
		tick(1);
		`CHK(sync_pulse, 1'b0)
		`CHK(chip_sync, 1'b0)
		apb(1'b1, OFF_CONTROL, 32'h1E, 4'hF);
		for (i = 0; i < 3; i++)
		begin
			tick(1);
			`CHK(sync_pulse, 1'b0)
		end
		// Mode off: chip sync follows the external input one cycle late.
		apb(1'b1, OFF_CONTROL, 32'h0E, 4'hF);
		for (i = 0; i < 8; i++)
		begin
			x = $urandom;
			@(posedge mclk);
			ext_sync <= x;
			tick(1);
			`CHK(chip_sync, x)
		end
		@(posedge mclk);
		ext_sync <= 1'b0;
		apb(1'b1, OFF_CONTROL, 32'h2E, 4'hF);
		tick(1);
		`CHK(chip_sync, 1'b0)
		done("sync");
		// Alarms: every enable pattern, with and without collision shutdown.
		apb(1'b1, OFF_MASK, 32'h7, 4'hF);
		for (i = 0; i < 16; i++)
		begin
			e = i[2:0];
			c = (i < 2 || i == 15) ? 3'h7 : 3'($urandom);
			apb(1'b1, OFF_CONTROL, (i[3] << 9) | (e << 1), 4'hF);
			apb(1'b1, OFF_STATUS, 32'h7, 4'hF);
			@(posedge mclk);
			ptr_cond <= c;
			tick(1);
			`CHK(output_off, c[0] & e[0] & i[3])
			`CHK(alarm_en, e)
			@(posedge mclk);
			ptr_cond <= 3'h0;
			tick(1);
			`CHK(output_off, 1'b0)
			apb(1'b0, OFF_STATUS, 32'h0, 4'hF);
			`CHK(rd[2:0], c & e)
			`CHK(irq, |(c & e))
			apb(1'b1, OFF_MASK, 32'h0, 4'hF);
			#1;
			`CHK(irq, 1'b0)
			apb(1'b1, OFF_MASK, 32'h7, 4'hF);
			apb(1'b1, OFF_STATUS, {29'h0, c & e}, 4'hF);
			apb(1'b0, OFF_STATUS, 32'h0, 4'hF);
			`CHK(rd, 32'h0)
		end
		done("alarms");
		give_verdict();
	end

endmodule

`default_nettype wire
